// ==== rtl/pio_pkg.sv ====
// package of the parallel i/o ports: i/o addresses, widths, reset values
// assumes an 8-bit cpu i/o space with 8-bit data
`default_nettype none
package pio_pkg;
  // ----------------------------------------------------------------------
  // bus types
  // ----------------------------------------------------------------------
  typedef logic [7:0] pio_addr_t;
  typedef logic [7:0] pio_byte_t;

  // ----------------------------------------------------------------------
  // i/o addresses
  // ----------------------------------------------------------------------
  localparam pio_addr_t PA_DATA0_ADDR = 8'h2c;
  localparam pio_addr_t PA_DIR0_ADDR = 8'h2d;
  localparam pio_addr_t PA_DATA1_ADDR = 8'h2e;
  localparam pio_addr_t PA_DIR1_ADDR = 8'h2f;
  localparam pio_addr_t PB_DATA0_ADDR = 8'h30;
  localparam pio_addr_t PB_DATA1_ADDR = 8'h31;
  localparam pio_addr_t PB_DATA2_ADDR = 8'h32;
  localparam pio_addr_t PB_CMD_ADDR = 8'h33;

  // ----------------------------------------------------------------------
  // fields and widths
  // ----------------------------------------------------------------------
  localparam int PA_WIDTH = 16;
  localparam int PB_WIDTH = 24;
  localparam int PB_GROUP = 4;
  localparam int PB_GROUPS = 6;
  localparam int CMD_SEL_MSB = 7;
  localparam int CMD_SEL_LSB = 6;
  localparam logic [1:0] CMD_DIR_LOAD = 2'h0;

  // ----------------------------------------------------------------------
  // reset values and synchroniser depth
  // ----------------------------------------------------------------------
  localparam pio_byte_t DATA_RESET = 8'h00;
  localparam pio_byte_t PA_DIR_RESET = 8'h00;
  localparam logic [PB_GROUPS-1:0] PB_DIR_RESET = 6'h00;
  localparam int SYNC_STAGES = 3;
endpackage
`default_nettype wire

// ==== rtl/pio_pin_if.sv ====
// interface between the port logic and its pin input filter
// assumes the filter and the user share one clock
`timescale 1ns/100ps
`default_nettype none
interface pio_pin_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  modport sync_side (input raw, output level);
  modport user_side (output raw, input level);
endinterface
`default_nettype wire

// ==== rtl/pio_pin_sync.sv ====
// three-stage pin input synchroniser with agreement filter
// assumes asynchronous pin levels on p.raw
`timescale 1ns/100ps
`default_nettype none
module pio_pin_sync
  import pio_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic clock,
  input wire logic rst,
  pio_pin_if.sync_side p
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] level;

  if (W < 1)
  begin : g_width_check
    $error("pio_pin_sync: width must be at least one");
  end

  // stage1 is read only by stage2
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= p.raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts once stage2 and stage3 agree
  always_ff @(posedge clock)
  begin
    if (rst)
      level <= '0;
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (stage2[i] == stage3[i])
          level[i] <= stage2[i];
      end
    end
  end

  assign p.level = level;
endmodule
`default_nettype wire

// ==== rtl/pio_ports.sv ====
// parallel i/o ports: 16-bit port a with per-bit direction,
// 24-bit port b with per-nibble direction set by command
// assumes a single-cycle cpu i/o strobe bus on clock
`timescale 1ns/100ps
`default_nettype none
module pio_ports
  import pio_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire pio_pkg::pio_addr_t io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire pio_pkg::pio_byte_t io_wdata,
  output pio_pkg::pio_byte_t io_rdata,
  output logic io_rvalid,
  input wire logic [pio_pkg::PA_WIDTH-1:0] pa_in,
  output logic [pio_pkg::PA_WIDTH-1:0] pa_out,
  output logic [pio_pkg::PA_WIDTH-1:0] pa_oe_n,
  input wire logic [pio_pkg::PB_WIDTH-1:0] pb_in,
  output logic [pio_pkg::PB_WIDTH-1:0] pb_out,
  output logic [pio_pkg::PB_WIDTH-1:0] pb_oe_n
);
  import pio_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic pio_byte_t mix(pio_byte_t stored, pio_byte_t pins, pio_byte_t dir);
    mix = (stored & dir) | (pins & ~dir);
  endfunction

  function automatic logic [PB_WIDTH-1:0] expand(logic [PB_GROUPS-1:0] grp);
    logic [PB_WIDTH-1:0] r;
    r = '0;
    for (int g = 0; g < PB_GROUPS; g++)
      r[g*PB_GROUP +: PB_GROUP] = {PB_GROUP{grp[g]}};
    expand = r;
  endfunction

  // ----------------------------------------------------------------------
  // pin input filters
  // ----------------------------------------------------------------------
  pio_pin_if #(.W(PA_WIDTH)) pa_pin ();
  pio_pin_if #(.W(PB_WIDTH)) pb_pin ();
  assign pa_pin.raw = pa_in;
  assign pb_pin.raw = pb_in;

  pio_pin_sync #(.W(PA_WIDTH)) u_pa_sync (.clock(clock), .rst(rst), .p(pa_pin));
  pio_pin_sync #(.W(PB_WIDTH)) u_pb_sync (.clock(clock), .rst(rst), .p(pb_pin));

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  pio_byte_t pa_data0;
  pio_byte_t pa_data1;
  pio_byte_t pa_dir0;
  pio_byte_t pa_dir1;
  pio_byte_t pb_data0;
  pio_byte_t pb_data1;
  pio_byte_t pb_data2;
  logic [PB_GROUPS-1:0] pb_dir;
  logic [1:0] cmd_sel;
  pio_byte_t next_rdata;
  logic next_rvalid;

  assign cmd_sel = io_wdata[CMD_SEL_MSB:CMD_SEL_LSB];

  // group direction spread to one bit per pin, for the read mix
  logic [PB_WIDTH-1:0] pb_dir_bits;
  assign pb_dir_bits = expand(pb_dir);

  // port a data and direction
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pa_data0 <= DATA_RESET;
      pa_data1 <= DATA_RESET;
      pa_dir0 <= PA_DIR_RESET;
      pa_dir1 <= PA_DIR_RESET;
    end
    else if (io_wr)
    begin
      if (io_addr == PA_DATA0_ADDR)
        pa_data0 <= io_wdata;
      if (io_addr == PA_DATA1_ADDR)
        pa_data1 <= io_wdata;
      if (io_addr == PA_DIR0_ADDR)
        pa_dir0 <= io_wdata;
      if (io_addr == PA_DIR1_ADDR)
        pa_dir1 <= io_wdata;
    end
  end

  // port b data
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pb_data0 <= DATA_RESET;
      pb_data1 <= DATA_RESET;
      pb_data2 <= DATA_RESET;
    end
    else if (io_wr)
    begin
      if (io_addr == PB_DATA0_ADDR)
        pb_data0 <= io_wdata;
      if (io_addr == PB_DATA1_ADDR)
        pb_data1 <= io_wdata;
      if (io_addr == PB_DATA2_ADDR)
        pb_data2 <= io_wdata;
    end
  end

  // port b command: only the direction load is acted on, others ignored
  always_ff @(posedge clock)
  begin
    if (rst)
      pb_dir <= PB_DIR_RESET;
    else if (io_wr && io_addr == PB_CMD_ADDR && cmd_sel == CMD_DIR_LOAD)
      pb_dir <= io_wdata[PB_GROUPS-1:0];
  end

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pa_out <= '0;
      pb_out <= '0;
    end
    else
    begin
      pa_out <= {pa_data1, pa_data0};
      pb_out <= {pb_data2, pb_data1, pb_data0};
    end
  end

  // enables low while driving; one cycle behind the direction registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pa_oe_n <= '1;
      pb_oe_n <= '1;
    end
    else
    begin
      pa_oe_n <= ~{pa_dir1, pa_dir0};
      pb_oe_n <= ~expand(pb_dir);
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    next_rvalid = io_rd;
    unique case (io_addr)
      PA_DATA0_ADDR: next_rdata = mix(pa_data0, pa_pin.level[7:0], pa_dir0);
      PA_DATA1_ADDR: next_rdata = mix(pa_data1, pa_pin.level[15:8], pa_dir1);
      PA_DIR0_ADDR: next_rdata = pa_dir0;
      PA_DIR1_ADDR: next_rdata = pa_dir1;
      PB_DATA0_ADDR: next_rdata = mix(pb_data0, pb_pin.level[7:0], pb_dir_bits[7:0]);
      PB_DATA1_ADDR: next_rdata = mix(pb_data1, pb_pin.level[15:8], pb_dir_bits[15:8]);
      PB_DATA2_ADDR: next_rdata = mix(pb_data2, pb_pin.level[23:16], pb_dir_bits[23:16]);
      PB_CMD_ADDR: next_rdata = {2'h0, pb_dir};
      default: next_rvalid = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      io_rdata <= 8'h00;
      io_rvalid <= 1'b0;
    end
    else
    begin
      io_rdata <= io_rd ? next_rdata : 8'h00;
      io_rvalid <= next_rvalid;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_reset_release;
    rst ##1 !rst;
  endsequence

  sequence s_dir_cmd;
    io_wr && io_addr == PB_CMD_ADDR && cmd_sel == CMD_DIR_LOAD;
  endsequence

  a_read_pin_mix: assert property (io_rd && io_addr == PA_DATA0_ADDR |=> io_rvalid
    && io_rdata == mix($past(pa_data0), $past(pa_pin.level[7:0]), $past(pa_dir0)))
    else $error("port a read does not mix pins and data");
  a_write_drive: assert property (io_wr && io_addr == PB_DATA1_ADDR |=> ##1
    pb_out[15:8] == $past(io_wdata, 2))
    else $error("port b write not driven on pins");
  a_reset_clears: assert property (disable iff (1'b0) rst |=> pa_data0 == 8'h00
    && pa_data1 == 8'h00 && pa_dir0 == 8'h00 && pa_dir1 == 8'h00 && pb_dir == 6'h00)
    else $error("reset left port registers set");
  a_release_input: assert property (disable iff (1'b0) s_reset_release |->
    &pa_oe_n && &pb_oe_n && pa_out == 16'h0000)
    else $error("pin driven right after reset");
  a_cmd_load_dir: assert property (s_dir_cmd |=> pb_dir == $past(io_wdata[5:0]))
    else $error("direction command not loaded");
  a_cmd_other_kept: assert property (io_wr && io_addr == PB_CMD_ADDR
    && cmd_sel != CMD_DIR_LOAD |=> $stable(pb_dir))
    else $error("non-direction command changed direction");
  a_dir_readback: assert property (io_rd && io_addr == PB_CMD_ADDR |=> io_rvalid
    && io_rdata == {2'h0, $past(pb_dir)})
    else $error("direction read back wrong");
  a_group_enable: assert property (s_dir_cmd |=> ##1
    pb_oe_n[23:20] == {4{~$past(io_wdata[5], 2)}} && pb_oe_n[3:0] == {4{~$past(io_wdata[0], 2)}})
    else $error("nibble group enable wrong");
  a_pa_bit_enable: assert property (##1 pa_oe_n == ~$past({pa_dir1, pa_dir0}))
    else $error("port a per-bit enable wrong");
  a_unmapped_quiet: assert property (io_rd && (io_addr < PA_DATA0_ADDR
    || io_addr > PB_CMD_ADDR) |=> !io_rvalid && io_rdata == 8'h00)
    else $error("unmapped read answered");
endmodule
`default_nettype wire

// ==== tb/pio_pin_model.sv ====
// pin model: resolves each port pin from device drive or an external level
// assumes active-low output enables from the port logic
`timescale 1ns/100ps
`default_nettype none
module pio_pin_model
(
  input wire logic [pio_pkg::PA_WIDTH-1:0] pa_out,
  input wire logic [pio_pkg::PA_WIDTH-1:0] pa_oe_n,
  input wire logic [pio_pkg::PA_WIDTH-1:0] pa_ext,
  input wire logic [pio_pkg::PB_WIDTH-1:0] pb_out,
  input wire logic [pio_pkg::PB_WIDTH-1:0] pb_oe_n,
  input wire logic [pio_pkg::PB_WIDTH-1:0] pb_ext,
  output logic [pio_pkg::PA_WIDTH-1:0] pa_in,
  output logic [pio_pkg::PB_WIDTH-1:0] pb_in
);
  import pio_pkg::*;
  // external device drives only pins left as inputs
  assign pa_in = (pa_out & ~pa_oe_n) | (pa_ext & pa_oe_n);
  assign pb_in = (pb_out & ~pb_oe_n) | (pb_ext & pb_oe_n);
endmodule
`default_nettype wire

// ==== tb/tb_parallel_io_ports.sv ====
// testbench of the parallel i/o ports
// assumes the pin model on the far side of every port pin
`timescale 1ns/100ps
`default_nettype none
module tb_parallel_io_ports;
  import pio_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  pio_addr_t io_addr = 8'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  pio_byte_t io_wdata = 8'h00;
  pio_byte_t io_rdata;
  logic io_rvalid;
  logic [PA_WIDTH-1:0] pa_in, pa_out, pa_oe_n;
  logic [PA_WIDTH-1:0] pa_ext = 16'h0000;
  logic [PB_WIDTH-1:0] pb_in, pb_out, pb_oe_n;
  logic [PB_WIDTH-1:0] pb_ext = 24'h000000;
  int err_total = 0;
  int tests_run = 0;

  pio_ports i_pio_ports (.clock(clock), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_in(pb_in),
    .pb_out(pb_out), .pb_oe_n(pb_oe_n));
  pio_pin_model i_pio_pin_model (.pa_out(pa_out), .pa_oe_n(pa_oe_n), .pa_ext(pa_ext),
    .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_ext(pb_ext), .pa_in(pa_in), .pb_in(pb_in));

  initial
  begin
    forever #2.5 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------------
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input pio_addr_t a, input pio_byte_t d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    settle(1);
    io_wr = 1'b0;
    // one idle edge so a following call never re-raises the strobe at once
    settle(1);
  endtask
  task automatic rd(input pio_addr_t a, output pio_byte_t d, output logic v);
    io_addr = a;
    io_rd = 1'b1;
    settle(1);
    // answer stands for the one cycle after the strobe edge
    d = io_rdata;
    v = io_rvalid;
    io_rd = 1'b0;
    settle(1);
  endtask
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_rd(input string n, input pio_addr_t a, input logic v_e,
    input pio_byte_t e);
    pio_byte_t d;
    logic v;
    rd(a, d, v);
    chk({n, " valid"}, {23'h0, v_e}, {23'h0, v});
    chk(n, {16'h0, e}, {16'h0, d});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset;
    chk("pa_oe_n", 24'h00ffff, {8'h0, pa_oe_n});
    chk("pb_oe_n", 24'hffffff, pb_oe_n);
    chk("pa_out", 24'h0, {8'h0, pa_out});
    chk("pb_out", 24'h0, pb_out);
    chk_rd("pa dir0", PA_DIR0_ADDR, 1'b1, 8'h00);
    chk_rd("pa dir1", PA_DIR1_ADDR, 1'b1, 8'h00);
    chk_rd("pa data0", PA_DATA0_ADDR, 1'b1, 8'h00);
    chk_rd("pb dir", PB_CMD_ADDR, 1'b1, 8'h00);
    $display("test reset done");
  endtask
  task automatic test_port_a;
    wr(PA_DIR0_ADDR, 8'h5a);
    wr(PA_DIR1_ADDR, 8'hc3);
    wr(PA_DATA0_ADDR, 8'hff);
    wr(PA_DATA1_ADDR, 8'h00);
    pa_ext = 16'h0f0f;
    settle(6);
    chk("pa_oe_n", 24'h003ca5, {8'h0, pa_oe_n});
    chk("pa_out", 24'h0000ff, {8'h0, pa_out});
    chk_rd("pa data0", PA_DATA0_ADDR, 1'b1, 8'h5f);
    chk_rd("pa data1", PA_DATA1_ADDR, 1'b1, 8'h0c);
    chk_rd("pa dir1", PA_DIR1_ADDR, 1'b1, 8'hc3);
    $display("test port a done");
  endtask
  task automatic test_port_b;
    for (int g = 0; g < PB_GROUPS; g++)
    begin
      wr(PB_CMD_ADDR, 8'h01 << g);
      settle(1);
      chk("pb_oe_n", ~(24'hf << (4 * g)), pb_oe_n);
      chk_rd("pb dir", PB_CMD_ADDR, 1'b1, 8'h01 << g);
    end
    for (int c = 1; c < 4; c++)
    begin
      wr(PB_CMD_ADDR, {c[1:0], 6'h3f});
      settle(1);
      chk("pb_oe_n", 24'h0fffff, pb_oe_n);
    end
    wr(PB_CMD_ADDR, 8'h15);
    wr(PB_DATA0_ADDR, 8'ha5);
    wr(PB_DATA1_ADDR, 8'h5a);
    wr(PB_DATA2_ADDR, 8'h3c);
    pb_ext = 24'hc396e1;
    settle(6);
    chk("pb_oe_n", 24'hf0f0f0, pb_oe_n);
    chk("pb_out", 24'h3c5aa5, pb_out);
    chk_rd("pb data0", PB_DATA0_ADDR, 1'b1, 8'he5);
    chk_rd("pb data1", PB_DATA1_ADDR, 1'b1, 8'h9a);
    chk_rd("pb data2", PB_DATA2_ADDR, 1'b1, 8'hcc);
    chk_rd("unmapped", 8'h34, 1'b0, 8'h00);
    $display("test port b done");
  endtask

  initial
  begin
    #20000;
    err_total++;
    complete_run;
  end

  initial
  begin
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    settle(1);
    test_reset;
    test_port_a;
    test_port_b;
    pa_ext = 16'h0000;
    pb_ext = 24'h000000;
    rst = 1'b1;
    settle(6);
    rst = 1'b0;
    settle(1);
    test_reset;
    complete_run;
  end
endmodule
`default_nettype wire
